/* logic/sdcp_ctrl.sv */
// sdram control-pin behaviour with apb status and write buffer
// Function
// - all inputs captured on rising clock edge
// - each running edge advances output registers, each burst beat the column
// - clock gate high runs, low freezes state
// - bank state picks powerdown, self refresh, suspend
// - clock gate sampled on the rising edge inside powerdown
// - input receivers off in powerdown, self refresh
// - device select high masks every command
// - bursts and masking continue while deselected
// - row, column, write strobes plus select encode
// - masked write bytes are discarded
// - masked read lanes float two clocks later
// - low mask bits 7-0, high 15-8
// - bank select picks target bank
// - scope bit high precharges all banks
// - scope bit requests auto precharge; low bits column
// - activate address selects row and bank
`timescale 1ns/1ps
module sdcp_ctrl (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [sdcp_pkg::PADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sdcp_pkg::PDATA_W-1:0] pwdata,
  output logic [sdcp_pkg::PDATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [sdcp_pkg::BA_W-1:0] ba,
  input wire logic [sdcp_pkg::ADR_W-1:0] addr,
  input wire logic [sdcp_pkg::DQ_W-1:0] dq_in,
  input wire logic low_byte_mask,
  input wire logic high_byte_mask,
  output logic [sdcp_pkg::DQ_W-1:0] dq_out,
  output logic [sdcp_pkg::DQ_W-1:0] dq_oe,
  output logic rx_enable,
  output logic wr_buf_ready
);
  import sdcp_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // state
  sdcp_pwr_t pwr_r, pwr_nxt;
  logic [NBANK-1:0] open_r, open_nxt;
  logic [ADR_W-1:0] row_r [NBANK];
  logic [ADR_W-1:0] row_nxt [NBANK];
  logic burst_r, burst_nxt;
  logic bwr_r, bwr_nxt;
  logic bap_r, bap_nxt;
  logic [BA_W-1:0] bbank_r, bbank_nxt;
  logic [COL_W-1:0] col_r, col_nxt;
  logic [LEFT_W-1:0] left_r, left_nxt;
  logic p1_valid_r, p1_valid_nxt;
  logic [DQ_W-1:0] p1_data_r, p1_data_nxt;
  logic [1:0] p1_mask_r, p1_mask_nxt;
  logic [DQ_W-1:0] dq_out_r, dq_out_nxt;
  logic [DQ_W-1:0] dq_oe_r, dq_oe_nxt;
  logic rx_enable_r, rx_enable_nxt;
  logic wr_buf_ready_r, wr_buf_ready_nxt;
  logic [1:0] ctrl_r, ctrl_nxt;
  logic [15:0] pattern_r, pattern_nxt;
  logic [1:0] err_r, err_nxt;
  logic [15:0] cmdcnt_r, cmdcnt_nxt;
  logic [PDATA_W-1:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;

  // working signals
  sdcp_cmd_t cmd;
  logic advance, cmd_on, start, beat, push, pop, setup, access;
  logic b_wr, b_ap;
  logic ev_closed;
  logic [BA_W-1:0] b_bank;
  logic [COL_W-1:0] b_col;
  logic [LEFT_W-1:0] b_left, blen;
  logic [1:0] mask_now;
  logic buf_in_ready, buf_out_valid;
  logic [BUF_W-1:0] buf_in_data, buf_out_data;
  logic [BUF_AW:0] buf_count;

  //////////////////////////////////////////////////////////////////////////
  // write buffer between the pins and software
  sdcp_fifo #(
    .W(BUF_W),
    .D(BUF_D),
    .AW(BUF_AW)
  ) u_wbuf (
    .clk(sys_clk),
    .srst(srst),
    .in_valid(push),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(buf_out_valid),
    .out_ready(pop),
    .out_data(buf_out_data),
    .count(buf_count)
  );

  //////////////////////////////////////////////////////////////////////////
  // pin side: power state, banks, burst and data path
  always_comb begin
    pwr_nxt = pwr_r;
    open_nxt = open_r;
    row_nxt = row_r;
    burst_nxt = burst_r;
    bwr_nxt = bwr_r;
    bap_nxt = bap_r;
    bbank_nxt = bbank_r;
    col_nxt = col_r;
    left_nxt = left_r;
    p1_valid_nxt = p1_valid_r;
    p1_data_nxt = p1_data_r;
    p1_mask_nxt = p1_mask_r;
    dq_out_nxt = dq_out_r;
    dq_oe_nxt = dq_oe_r;
    err_nxt = err_r;
    cmdcnt_nxt = cmdcnt_r;
    push = 1'b0;
    // command code from the three strobes, sampled this edge
    cmd = sdcp_cmd_t'({ras_n, cas_n, we_n});
    mask_now = {high_byte_mask, low_byte_mask};
    // internal clock runs only in run state with the gate high
    advance = (pwr_r == SDCP_RUN) && cke;
    cmd_on = advance && !cs_n;
    blen = LEFT_W'(1) << ctrl_r;
    start = cmd_on && (cmd == SDCP_CMD_READ || cmd == SDCP_CMD_WRITE)
      && open_r[ba];
    // read or write aimed at a closed bank, raised in the error register
    ev_closed = cmd_on && (cmd == SDCP_CMD_READ || cmd == SDCP_CMD_WRITE)
      && !open_r[ba];
    b_wr = start ? (cmd == SDCP_CMD_WRITE) : bwr_r;
    b_ap = start ? addr[SCOPE_POS] : bap_r;
    b_bank = start ? ba : bbank_r;
    b_col = start ? addr[COL_W-1:0] : col_r;
    b_left = start ? blen : left_r;
    beat = advance && (start || burst_r) &&
      !(cmd_on && cmd == SDCP_CMD_TERMINATE);
    buf_in_data = {~mask_now, dq_in & {{LANE_W{~mask_now[1]}},
      {LANE_W{~mask_now[0]}}}};

    // power state selection from bank state
    unique case (pwr_r)
      SDCP_RUN: begin
        if (!cke) begin
          // a read pipeline still draining counts as a burst
          if (burst_r || p1_valid_r || (|dq_oe_r)) begin
            pwr_nxt = SDCP_SUSPEND;
          end else if (|open_r) begin
            pwr_nxt = SDCP_PDN_ACT;
          end else if (!cs_n && cmd == SDCP_CMD_REFRESH) begin
            pwr_nxt = SDCP_SELF_REF;
          end else begin
            pwr_nxt = SDCP_PDN_PRE;
          end
        end
      end
      SDCP_SUSPEND: begin
        if (cke) begin
          pwr_nxt = SDCP_RUN;
        end
      end
      // gate level alone exits, no command needed
      SDCP_PDN_PRE, SDCP_PDN_ACT, SDCP_SELF_REF: begin
        if (cke) begin
          pwr_nxt = SDCP_RUN;
        end
      end
    endcase

    // commands on the banks
    if (cmd_on && cmd != SDCP_CMD_NOP) begin
      cmdcnt_nxt = cmdcnt_r + 16'h0001;
    end
    if (cmd_on && cmd == SDCP_CMD_ACTIVATE) begin
      open_nxt[ba] = 1'b1;
      row_nxt[ba] = addr;
    end
    if (cmd_on && cmd == SDCP_CMD_PRECHARGE) begin
      if (addr[SCOPE_POS]) begin
        open_nxt = '0;
      end else begin
        open_nxt[ba] = 1'b0;
      end
    end
    if (ev_closed) begin
      err_nxt[ERR_CLOSED_POS] = 1'b1;
    end
    if (cmd_on && cmd == SDCP_CMD_TERMINATE) begin
      burst_nxt = 1'b0;
    end

    // one burst beat per running edge
    if (beat) begin
      col_nxt = b_col + 1'b1;
      left_nxt = b_left - 1'b1;
      bwr_nxt = b_wr;
      bap_nxt = b_ap;
      bbank_nxt = b_bank;
      burst_nxt = (b_left != LEFT_W'(1));
      if (b_left == LEFT_W'(1) && b_ap) begin
        open_nxt[b_bank] = 1'b0;
      end
      push = b_wr && (mask_now != 2'h3);
    end

    // read pipeline, mask delayed alongside the data
    if (advance) begin
      p1_valid_nxt = beat && !b_wr;
      p1_data_nxt = pattern_r ^ {5'h00, b_bank, b_col};
      p1_mask_nxt = mask_now;
      dq_out_nxt = p1_data_r;
      dq_oe_nxt = {{LANE_W{p1_valid_r && !p1_mask_r[1]}},
        {LANE_W{p1_valid_r && !p1_mask_r[0]}}};
    end
    if (push && !buf_in_ready) begin
      err_nxt[ERR_OVF_POS] = 1'b1;
    end
    rx_enable_nxt = (pwr_nxt == SDCP_RUN) ||
      (pwr_nxt == SDCP_SUSPEND);
    wr_buf_ready_nxt = (buf_count < (BUF_AW+1)'(BUF_D - 1)) ||
      (buf_count == (BUF_AW+1)'(BUF_D - 1) && !push);

    // software clear of error flags, a new event wins
    if (access && pwrite && paddr == OFS_ERROR) begin
      err_nxt = err_nxt & ~(pwdata[1:0] & ~{push && !buf_in_ready,
        ev_closed});
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pwr_r <= SDCP_RUN;
      open_r <= '0;
      row_r <= '{default: '0};
      burst_r <= 1'b0;
      bwr_r <= 1'b0;
      bap_r <= 1'b0;
      bbank_r <= '0;
      col_r <= '0;
      left_r <= '0;
      p1_valid_r <= 1'b0;
      p1_data_r <= '0;
      p1_mask_r <= '0;
      dq_out_r <= '0;
      dq_oe_r <= '0;
      err_r <= '0;
      cmdcnt_r <= '0;
      rx_enable_r <= 1'b1;
      wr_buf_ready_r <= 1'b1;
    end else begin
      pwr_r <= pwr_nxt;
      open_r <= open_nxt;
      row_r <= row_nxt;
      burst_r <= burst_nxt;
      bwr_r <= bwr_nxt;
      bap_r <= bap_nxt;
      bbank_r <= bbank_nxt;
      col_r <= col_nxt;
      left_r <= left_nxt;
      p1_valid_r <= p1_valid_nxt;
      p1_data_r <= p1_data_nxt;
      p1_mask_r <= p1_mask_nxt;
      dq_out_r <= dq_out_nxt;
      dq_oe_r <= dq_oe_nxt;
      err_r <= err_nxt;
      cmdcnt_r <= cmdcnt_nxt;
      rx_enable_r <= rx_enable_nxt;
      wr_buf_ready_r <= wr_buf_ready_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // apb slave, one wait-free access phase
  always_comb begin
    setup = psel && !penable;
    access = psel && penable && pready_r;
    pop = access && !pwrite && paddr == OFS_WDATA && buf_out_valid;
    ctrl_nxt = ctrl_r;
    pattern_nxt = pattern_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    pready_nxt = setup;
    if (setup) begin
      prdata_nxt = '0;
      unique case (paddr)
        OFS_CTRL: prdata_nxt[1:0] = ctrl_r;
        OFS_STATUS: begin
          prdata_nxt[ST_PWR_LSB +: 3] = pwr_r;
          prdata_nxt[ST_BANK_LSB +: NBANK] = open_r;
          prdata_nxt[ST_BURST_POS] = burst_r;
          prdata_nxt[ST_WRITE_POS] = bwr_r;
          prdata_nxt[ST_RX_POS] = rx_enable_r;
          prdata_nxt[ST_BUFRDY_POS] = wr_buf_ready_r;
        end
        OFS_ERROR: prdata_nxt[1:0] = err_r;
        OFS_WDATA: begin
          prdata_nxt[WD_VALID_POS] = buf_out_valid;
          prdata_nxt[BUF_W-1:0] = buf_out_valid ? buf_out_data : '0;
        end
        OFS_PATTERN: prdata_nxt[15:0] = pattern_r;
        OFS_CMDCNT: prdata_nxt[15:0] = cmdcnt_r;
        default: pslverr_nxt = 1'b1;
      endcase
    end
    // writes take effect at the access edge
    if (access && pwrite) begin
      if (paddr == OFS_CTRL) begin
        ctrl_nxt = pwdata[1:0];
      end
      if (paddr == OFS_PATTERN) begin
        pattern_nxt = pwdata[15:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_r <= CTRL_RST;
      pattern_r <= PATTERN_RST;
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      pattern_r <= pattern_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // outputs straight from flops
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign dq_out = dq_out_r;
  assign dq_oe = dq_oe_r;
  assign rx_enable = rx_enable_r;
  assign wr_buf_ready = wr_buf_ready_r;
endmodule // sdcp_ctrl

/* logic/sdcp_fifo.sv */
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module sdcp_fifo #(
  parameter int W = 18,
  parameter int D = 8,
  parameter int AW = 3
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [AW:0] count
);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  // handshake and pointer updates
  always_comb begin
    push = in_valid && (cnt_r != (AW+1)'(D));
    pop = out_ready && (cnt_r != '0);
    wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
    rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  assign in_ready = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_ptr_r];
  assign count = cnt_r;
endmodule // sdcp_fifo

/* logic/sdcp_pkg.sv */
// shared constants and types for the sdram control-pin block
package sdcp_pkg;
  // pin widths
  localparam int DQ_W = 16;
  localparam int BA_W = 2;
  localparam int ADR_W = 13;
  localparam int COL_W = 9;
  localparam int NBANK = 4;
  localparam int LEFT_W = 4;
  // bit positions within the address pins
  localparam int SCOPE_POS = 10;
  localparam int LANE_W = 8;
  // read path stages, one per clock of read latency
  localparam int RD_STAGES = 2;
  // write buffer
  localparam int BUF_W = 18;
  localparam int BUF_D = 8;
  localparam int BUF_AW = 3;
  // apb
  localparam int PADDR_W = 8;
  localparam int PDATA_W = 32;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ERROR = 8'h08;
  localparam logic [7:0] OFS_WDATA = 8'h0c;
  localparam logic [7:0] OFS_PATTERN = 8'h10;
  localparam logic [7:0] OFS_CMDCNT = 8'h14;
  // reset values
  localparam logic [1:0] CTRL_RST = 2'h3;
  localparam logic [15:0] PATTERN_RST = 16'h0000;
  // field positions
  localparam int ST_PWR_LSB = 0;
  localparam int ST_BANK_LSB = 4;
  localparam int ST_BURST_POS = 8;
  localparam int ST_WRITE_POS = 9;
  localparam int ST_RX_POS = 10;
  localparam int ST_BUFRDY_POS = 11;
  localparam int WD_VALID_POS = 31;
  localparam int ERR_CLOSED_POS = 0;
  localparam int ERR_OVF_POS = 1;
  // command code {ras_n, cas_n, we_n}
  typedef enum logic [2:0] {
    SDCP_CMD_MODE = 3'h0,
    SDCP_CMD_REFRESH = 3'h1,
    SDCP_CMD_PRECHARGE = 3'h2,
    SDCP_CMD_ACTIVATE = 3'h3,
    SDCP_CMD_WRITE = 3'h4,
    SDCP_CMD_READ = 3'h5,
    SDCP_CMD_TERMINATE = 3'h6,
    SDCP_CMD_NOP = 3'h7
  } sdcp_cmd_t;
  // power state, codes fixed so software can read them
  typedef enum logic [2:0] {
    SDCP_RUN = 3'h0,
    SDCP_SUSPEND = 3'h1,
    SDCP_PDN_PRE = 3'h2,
    SDCP_PDN_ACT = 3'h3,
    SDCP_SELF_REF = 3'h4
  } sdcp_pwr_t;
endpackage

/* tb/sdcp_ctrl_sva.sv */
// port-level assertions for the sdram control-pin block
`timescale 1ns/1ps
module sdcp_ctrl_chk (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cke,
  input wire logic low_byte_mask,
  input wire logic high_byte_mask,
  input wire logic [sdcp_pkg::DQ_W-1:0] dq_out,
  input wire logic [sdcp_pkg::DQ_W-1:0] dq_oe,
  input wire logic rx_enable
);
  import sdcp_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////
  // running edge that is not itself a wake-up edge
  sequence live_s;
    cke && $past(cke) && rx_enable;
  endsequence
  // one further running edge until the masked word shows
  sequence hold_s;
    cke;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  chk_apb_answer:
    assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  chk_ready_pulse:
    assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_pair:
    assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_low_float:
    assert property (low_byte_mask ##0 live_s ##1 hold_s
      |=> dq_oe[7:0] == 8'h00)
    else $error("low lane still driven after mask");
  chk_high_float:
    assert property (high_byte_mask ##0 live_s ##1 hold_s
      |=> dq_oe[15:8] == 8'h00)
    else $error("high lane still driven after mask");
  chk_gate_freeze:
    assert property (!cke |=> $stable(dq_out) && $stable(dq_oe))
    else $error("outputs moved while clock gated");
  chk_rx_drop:
    assert property ($fell(rx_enable) |-> !$past(cke) || !$past(cke, 2))
    else $error("receivers off without gate low");
  chk_rx_wake:
    assert property (!rx_enable && cke |-> ##[1:2] rx_enable)
    else $error("no wake-up after gate high");
  chk_sleep_quiet:
    assert property (!rx_enable |-> dq_oe == 16'h0000)
    else $error("driving while powered down");
endmodule // sdcp_ctrl_chk

/* tb/sdcp_mc.sv */
// memory controller model driving the device pins
`timescale 1ns/1ps
module sdcp_mc (
  input wire logic sys_clk,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [sdcp_pkg::BA_W-1:0] ba,
  output logic [sdcp_pkg::ADR_W-1:0] addr,
  output logic [sdcp_pkg::DQ_W-1:0] dq_in,
  output logic low_byte_mask,
  output logic high_byte_mask
);
  import sdcp_pkg::*;
  // gate held high, deselected nop at time zero
  initial begin
    {cke, cs_n, ras_n, cas_n, we_n, ba, addr, dq_in} = {5'h1f, 31'h0};
    {high_byte_mask, low_byte_mask} = 2'h0;
  end
  // all pins launched together just after an edge
  task automatic issue(input logic ck, input logic cs, input sdcp_cmd_t c,
      input logic [BA_W-1:0] b, input logic [ADR_W-1:0] a,
      input logic [DQ_W-1:0] d, input logic [1:0] m);
    @(posedge sys_clk);
    {cke, cs_n, ras_n, cas_n, we_n, ba, addr, dq_in} <= {ck, cs, c, b, a, d};
    {high_byte_mask, low_byte_mask} <= m;
  endtask
  // nops with a released data bus that keeps toggling
  task automatic idle(input logic ck, input int n);
    repeat (n) issue(ck, 1'b0, SDCP_CMD_NOP, 2'h0, 13'h0, ~dq_in, 2'h0);
  endtask
endmodule // sdcp_mc

/* tb/tb_sdcp_ctrl.sv */
// self-checking bench for the sdram control-pin block
`timescale 1ns/1ps
bind sdcp_ctrl sdcp_ctrl_chk chk (.sys_clk(sys_clk), .srst(srst),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .cke(cke), .low_byte_mask(low_byte_mask),
  .high_byte_mask(high_byte_mask), .dq_out(dq_out), .dq_oe(dq_oe),
  .rx_enable(rx_enable));
module tb_sdcp_ctrl;
  import sdcp_pkg::*;
  logic sys_clk = 1'b0;
  logic srst, psel, penable, pwrite, pready, pslverr;
  logic cke, cs_n, ras_n, cas_n, we_n, low_byte_mask, high_byte_mask;
  logic rx_enable, wr_buf_ready, err_seen;
  logic [PADDR_W-1:0] paddr;
  logic [PDATA_W-1:0] pwdata, prdata, q, we;
  logic [BA_W-1:0] ba;
  logic [ADR_W-1:0] addr;
  logic [DQ_W-1:0] dq_in, dq_out, dq_oe, oe_e, dat_e;
  int errors = 0;
  int checks_done = 0;
  ////////////////////////////////////////////////////////////////////////////
  // clock, device and controller model
  always #2 sys_clk = ~sys_clk;
  sdcp_ctrl dut (.sys_clk(sys_clk), .srst(srst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cke(cke),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
    .addr(addr), .dq_in(dq_in), .low_byte_mask(low_byte_mask),
    .high_byte_mask(high_byte_mask), .dq_out(dq_out), .dq_oe(dq_oe),
    .rx_enable(rx_enable), .wr_buf_ready(wr_buf_ready));
  sdcp_mc mc (.sys_clk(sys_clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq_in(dq_in),
    .low_byte_mask(low_byte_mask), .high_byte_mask(high_byte_mask));
  ////////////////////////////////////////////////////////////////////////////
  // compare one value
  task automatic check(input string w, input logic [31:0] s,
      input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", w, e, s);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    q = prdata;
    err_seen = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input string w);
    apb(1'b0, a, 32'h0);
    check(w, q, e);
  endtask
  // final verdict
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // watchdog against a hung handshake
  initial begin
    #100000;
    errors++;
    complete_run();
  end
  // main sequence
  initial begin
    {srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    rd(OFS_CTRL, 32'h3, "ctrl reset");
    rd(OFS_PATTERN, 32'h0, "pattern reset");
    rd(OFS_STATUS, 32'hc00, "status reset");
    rd(8'h40, 32'h0, "unmapped read");
    check("unmapped err", err_seen, 1'b1);
    apb(1'b1, OFS_PATTERN, 32'h5a3c);
    apb(1'b1, OFS_CTRL, 32'h2);
    mc.issue(1, 0, SDCP_CMD_ACTIVATE, 2'd1, 13'h0123, 0, 0);
    mc.issue(1, 1, SDCP_CMD_ACTIVATE, 2'd2, 13'h0, 0, 0);
    mc.idle(1, 1);
    rd(OFS_STATUS, 32'hc20, "bank open");
    // read with auto precharge, column wrap, masks, deselected read
    mc.issue(1, 0, SDCP_CMD_READ, 2'd1, 13'h05fe, 0, 0);
    for (int k = 1; k <= 7; k++) begin
      mc.issue(1, k == 2, k == 2 ? SDCP_CMD_READ : SDCP_CMD_NOP, 2'd0,
        13'h0, 16'h0, k == 1 ? 2'b01 : k == 2 ? 2'b10 : 2'b00);
      #1;
      oe_e = k >= 6 ? 16'h0 : k == 3 ? 16'hff00 : k == 4 ? 16'h00ff : '1;
      dat_e = 16'h5a3c ^ {7'h1, 9'(9'h1fe + k - 2)};
      if (k >= 2) check("read oe", dq_oe, oe_e);
      if (k >= 2) check("read data", dq_out & oe_e, dat_e & oe_e);
    end
    rd(OFS_STATUS, 32'hc00, "auto precharge");
    rd(OFS_CMDCNT, 32'h2, "cmd count");
    mc.issue(1, 0, SDCP_CMD_READ, 2'd1, 13'h0, 0, 0);
    mc.idle(1, 1);
    rd(OFS_ERROR, 32'h1, "closed bank");
    apb(1'b1, OFS_ERROR, 32'h1);
    rd(OFS_ERROR, 32'h0, "error clear");
    // single bank then all-bank precharge
    mc.issue(1, 0, SDCP_CMD_ACTIVATE, 2'd0, 13'h0, 0, 0);
    mc.issue(1, 0, SDCP_CMD_ACTIVATE, 2'd3, 13'h0, 0, 0);
    mc.issue(1, 0, SDCP_CMD_PRECHARGE, 2'd0, 13'h0, 0, 0);
    mc.idle(1, 1);
    rd(OFS_STATUS, 32'hc80, "one precharged");
    mc.issue(1, 0, SDCP_CMD_PRECHARGE, 2'd0, 13'h0400, 0, 0);
    mc.idle(1, 1);
    rd(OFS_STATUS, 32'hc00, "all precharged");
    // masked write burst, then a long burst that overflows the buffer
    mc.issue(1, 0, SDCP_CMD_ACTIVATE, 2'd2, 13'h0, 0, 0);
    mc.issue(1, 0, SDCP_CMD_WRITE, 2'd2, 13'h0, 16'h1234, 2'b00);
    mc.issue(1, 0, SDCP_CMD_NOP, 2'd0, 13'h0, 16'h5678, 2'b01);
    mc.issue(1, 0, SDCP_CMD_NOP, 2'd0, 13'h0, 16'h9999, 2'b11);
    mc.issue(1, 0, SDCP_CMD_NOP, 2'd0, 13'h0, 16'h9abc, 2'b10);
    mc.idle(1, 1);
    apb(1'b1, OFS_CTRL, 32'h3);
    for (int i = 0; i < 8; i++) begin
      mc.issue(1, 0, i == 0 ? SDCP_CMD_WRITE : SDCP_CMD_NOP, 2'd2, 13'h0,
        16'(16'h0100 + i), 2'b00);
    end
    mc.idle(1, 2);
    check("buffer full", wr_buf_ready, 1'b0);
    rd(OFS_ERROR, 32'h2, "overflow");
    for (int i = 0; i < 9; i++) begin
      we = i == 0 ? 32'h8003_1234 : i == 1 ? 32'h8002_5600 :
        i == 2 ? 32'h8001_00bc : i == 8 ? 32'h0 : 32'h8003_00fd + i;
      apb(1'b0, OFS_WDATA, 32'h0);
      if (i < 8) check("wdata", q, we);
      if (i == 8) check("wdata empty", q[31], 1'b0);
    end
    check("buffer free", wr_buf_ready, 1'b1);
    // gate low: active pdn, precharge pdn, self refresh, suspend
    for (int p = 0; p < 4; p++) begin
      if (p == 1) mc.issue(1, 0, SDCP_CMD_PRECHARGE, 0, 13'h0400, 0, 0);
      if (p == 3) mc.issue(1, 0, SDCP_CMD_ACTIVATE, 0, 13'h0, 0, 0);
      if (p == 3) mc.issue(1, 0, SDCP_CMD_READ, 0, 13'h0, 0, 0);
      mc.issue(0, 0, p == 2 ? SDCP_CMD_REFRESH : SDCP_CMD_NOP, 0, 0, 0, 0);
      mc.idle(0, 3);
      apb(1'b0, OFS_STATUS, 32'h0);
      check("power state", q[2:0],
        p == 0 ? 3 : p == 1 ? 2 : p == 2 ? 4 : 1);
      check("rx gated", rx_enable, p == 3);
      mc.idle(1, 3);
      check("rx back", rx_enable, 1'b1);
    end
    mc.idle(1, 10);
    rd(OFS_STATUS, 32'hc10, "run again");
    // burst of eight cut short by a terminate on the next edge
    mc.issue(1, 0, SDCP_CMD_READ, 2'd0, 13'h0, 0, 0);
    mc.issue(1, 0, SDCP_CMD_TERMINATE, 2'd0, 13'h0, 0, 0);
    mc.idle(1, 1);
    rd(OFS_STATUS, 32'hc10, "terminated");
    complete_run();
  end
endmodule // tb_sdcp_ctrl
